// [src/rbpf_defines.vh]
// constants for the basic packet framer
`ifndef RBPF_DEFINES_VH
`define RBPF_DEFINES_VH
// ----------------------------------------
// frame formats
// ----------------------------------------
`define RBPF_FMT_BASIC 2'h0
`define RBPF_FMT_G4G 2'h1
`define RBPF_FMT_UART 2'h2
`define RBPF_FMT_STACK 2'h3
// ----------------------------------------
// field sizes and reset values
// ----------------------------------------
`define RBPF_MAX_PREAMBLE_PAIRS 10'h3FF
`define RBPF_MAX_SYNC_BITS 6'h20
`define RBPF_CRC_POLY 32'h04C11DB7
`define RBPF_CRC_INIT 32'hFFFFFFFF
`define RBPF_POSTAMBLE_PATTERN 2'h1
`define RBPF_FIFO_DEPTH 16
`endif

// [src/rbpf_fifo.v]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rbpf_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_i,
	input wire nrst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o,
	output wire [AW:0] level_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr;
	reg [AW-1:0] rptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;

	// honest flags from the occupancy count
	assign in_ready_o = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign do_wr = in_valid_i & in_ready_o;
	assign do_rd = out_valid_o & out_ready_i;
	assign out_data_o = mem[rptr];
	assign level_o = count;

	// storage has no reset, pointers do
	always @(posedge clk_i) begin
		if (do_wr) begin
			mem[wptr] <= in_data_i;
		end
	end

	// pointer and count update
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr <= {AW{1'b0}};
			rptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
			end
			if (do_rd) begin
				rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
			end
			if (do_wr & ~do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd & ~do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// [src/rbpf_framer.v]
// basic-format packet framer and deframer with tx byte fifo
`timescale 1ns/1ps
`include "rbpf_defines.vh"
module rbpf_framer #(
	parameter DEPTH = `RBPF_FIFO_DEPTH,
	parameter PRE_DETECT_BITS = 16
) (
	input wire clk_i,
	input wire nrst_i,
	input wire [1:0] frame_format_select_i,
	input wire [9:0] preamble_pairs_i,
	input wire [1:0] preamble_sel_i,
	input wire four_level_i,
	input wire [5:0] sync_len_i,
	input wire [31:0] primary_sync_bytes_i,
	input wire [31:0] secondary_sync_bytes_i,
	input wire alt_sync_sel_i,
	input wire [7:0] tx_length_high_i,
	input wire [7:0] tx_length_low_i,
	input wire variable_length_enable_i,
	input wire length_field_width_i,
	input wire dest_address_enable_i,
	input wire [7:0] dest_address_i,
	input wire [7:0] rx_match_address_i,
	input wire [2:0] crc_bytes_i,
	input wire [7:0] postamble_pair_count_i,
	input wire tx_start_i,
	input wire tx_bit_en_i,
	input wire tx_data_valid_i,
	output wire tx_data_ready_o,
	input wire [7:0] tx_data_i,
	output reg tx_bit_o,
	output wire tx_busy_o,
	output reg tx_done_o,
	input wire rx_enable_i,
	input wire rx_bit_i,
	input wire rx_bit_valid_i,
	output reg [7:0] rx_data_o,
	output reg rx_data_valid_o,
	output reg [6:0] sync_quality_value_o,
	output reg sync_detect_o,
	output reg rx_frame_error_o,
	output reg rx_frame_ok_o
);
	// ----------------------------------------
	// state codes, one-hot
	// ----------------------------------------
	localparam S_IDLE = 8'h01;
	localparam S_PRE = 8'h02;
	localparam S_SYNC = 8'h04;
	localparam S_LEN = 8'h08;
	localparam S_ADDR = 8'h10;
	localparam S_PAY = 8'h20;
	localparam S_CRC = 8'h40;
	localparam S_POST = 8'h80;

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	// bitwise crc-32 step; bytes beyond crc_bytes are dropped from the top
	function [31:0] crc_step;
		input [31:0] c;
		input b;
		begin
			crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `RBPF_CRC_POLY : 32'h00000000);
		end
	endfunction

	// match address comes straight from its port and shares no storage
	// with the secondary sync word, so both can be in use
	wire [7:0] rx_match_eff = rx_match_address_i;
	wire basic_fmt = (frame_format_select_i == `RBPF_FMT_BASIC);
	wire [15:0] reg_len = {tx_length_high_i, tx_length_low_i};

	// tx fifo: source stalls when it fills, drained by the payload phase
	wire fifo_valid;
	wire [7:0] fifo_data;
	wire fifo_take;
	rbpf_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(4)) u_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(tx_data_valid_i),
		.in_ready_o(tx_data_ready_o),
		.in_data_i(tx_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_take),
		.out_data_o(fifo_data),
		.level_o()
	);

	// ----------------------------------------
	// transmit
	// ----------------------------------------
	reg [7:0] ts;
	reg [15:0] tcnt;
	reg [2:0] tbit;
	reg [7:0] tbyte;
	reg [31:0] tcrc;
	reg [15:0] tpay;
	wire [3:0] pre_seq;
	assign tx_busy_o = (ts != S_IDLE);

	// preamble table, leftmost bit first
	assign pre_seq = four_level_i ?
		((preamble_sel_i == 2'h0) ? 4'h7 : (preamble_sel_i == 2'h1) ? 4'h2 :
		(preamble_sel_i == 2'h2) ? 4'hD : 4'h8) :
		((preamble_sel_i == 2'h0) ? 4'h5 : (preamble_sel_i == 2'h1) ? 4'hA :
		(preamble_sel_i == 2'h2) ? 4'h3 : 4'hC);
	wire [31:0] tx_sync = alt_sync_sel_i ? secondary_sync_bytes_i : primary_sync_bytes_i;
	wire tx_len2 = variable_length_enable_i & length_field_width_i;
	wire [15:0] tpay_len = reg_len - {15'h0000, dest_address_enable_i};
	// payload phase pulls a byte only at the first bit, and only if available
	assign fifo_take = tx_bit_en_i & (ts == S_PAY) & (tbit == 3'h0) & fifo_valid &
		(tpay != 16'h0000);
	wire tx_stall = (ts == S_PAY) & (tbit == 3'h0) & ~fifo_valid;
	reg [7:0] cur_byte;
	always @* begin
		cur_byte = (ts == S_PAY && tbit == 3'h0) ? fifo_data : tbyte;
	end
	wire cur_bit = cur_byte[7 - tbit];
	wire [31:0] tcrc_nx = crc_step(tcrc, cur_bit);
	wire [2:0] crc_first = crc_bytes_i - 3'h1;
	wire [2:0] crc_next = crc_bytes_i - 3'h2 - tcnt[2:0];
	// crc goes out as its low bytes, msb first, as the receiver compares it
	wire [31:0] crc_first_w = ((tpay == 16'h0000) ? tcrc : tcrc_nx) >> {crc_first, 3'h0};
	wire [31:0] crc_next_w = tcrc >> {crc_next, 3'h0};
	wire [1:0] post_pat = `RBPF_POSTAMBLE_PATTERN;

	// serialiser walks the fields in frame order
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ts <= S_IDLE;
			tcnt <= 16'h0000;
			tbit <= 3'h0;
			tbyte <= 8'h00;
			tcrc <= `RBPF_CRC_INIT;
			tpay <= 16'h0000;
			tx_bit_o <= 1'b0;
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= 1'b0;
			case (ts)
			S_IDLE: begin
				if (tx_start_i && basic_fmt) begin
					ts <= S_PRE;
					tcnt <= 16'h0000;
					tcrc <= `RBPF_CRC_INIT;
				end
			end
			S_PRE: begin
				// field switch takes no strobe, so no bit slot repeats a stale bit
				if (tcnt >= {5'h00, preamble_pairs_i, 1'b0}) begin
					ts <= S_SYNC;
					tcnt <= 16'h0000;
				end else if (tx_bit_en_i) begin
					tx_bit_o <= pre_seq[3 - tcnt[1:0]];
					tcnt <= tcnt + 16'h0001;
				end
			end
			S_SYNC: begin
				if (tcnt[5:0] >= sync_len_i) begin
					ts <= S_LEN;
					tcnt <= 16'h0000;
					tbit <= 3'h0;
					tbyte <= tx_len2 ? reg_len[15:8] : reg_len[7:0];
				end else if (tx_bit_en_i) begin
					tx_bit_o <= tx_sync[31 - tcnt[4:0]];
					tcnt <= tcnt + 16'h0001;
				end
			end
			S_LEN, S_ADDR, S_PAY, S_CRC: begin
				if (ts == S_PAY && tpay == 16'h0000) begin
					// zero length payload skipped without spending a strobe
					ts <= S_CRC;
					tcnt <= 16'h0000;
					tbit <= 3'h0;
					tbyte <= crc_first_w[7:0];
				end else if (ts == S_CRC && crc_bytes_i == 3'h0) begin
					ts <= S_POST;
					tcnt <= 16'h0000;
				end else if (tx_bit_en_i && !tx_stall) begin
					tx_bit_o <= cur_bit;
					if (ts != S_CRC) begin
						tcrc <= crc_step(tcrc, cur_bit);
					end
					tbit <= tbit + 3'h1;
					if (tbit == 3'h0 && ts == S_PAY) begin
						tbyte <= fifo_data;
					end
					if (tbit == 3'h7) begin
						tcnt <= tcnt + 16'h0001;
						if (ts == S_LEN && tx_len2 && tcnt == 16'h0000) begin
							tbyte <= reg_len[7:0];
						end else if (ts == S_LEN && dest_address_enable_i) begin
							ts <= S_ADDR;
							tbyte <= dest_address_i;
						end else if (ts == S_LEN || ts == S_ADDR) begin
							ts <= S_PAY;
							tcnt <= 16'h0000;
							tpay <= tpay_len;
						end else if (ts == S_PAY && tcnt + 16'h0001 >= tpay) begin
							ts <= S_CRC;
							tcnt <= 16'h0000;
							tbyte <= crc_first_w[7:0];
						end else if (ts == S_CRC) begin
							tbyte <= crc_next_w[7:0];
						end
					end
					if (ts == S_CRC && tbit == 3'h7 &&
						tcnt + 16'h0001 >= {13'h0000, crc_bytes_i}) begin
						ts <= S_POST;
						tcnt <= 16'h0000;
					end
				end
			end
			S_POST: begin
				if (tx_bit_en_i) begin
					if (tcnt >= {7'h00, postamble_pair_count_i, 1'b0}) begin
						ts <= S_IDLE;
						tx_done_o <= 1'b1;
					end else begin
						tx_bit_o <= post_pat[~tcnt[0]];
						tcnt <= tcnt + 16'h0001;
					end
				end
			end
			default: ts <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receive
	// ----------------------------------------
	reg rx_m;
	reg rx_s;
	reg rv_m;
	reg rv_s;
	reg [7:0] rs;
	reg [31:0] rsh;
	reg [4:0] pre_run;
	reg [15:0] rcnt;
	reg [15:0] rlen;
	reg [2:0] rbit;
	reg [31:0] rcrc;
	reg [31:0] rcrc_got;
	reg addr_bad;
	wire [31:0] nsh = {rsh[30:0], rx_s};
	wire [31:0] smask = (sync_len_i >= `RBPF_MAX_SYNC_BITS) ? 32'hFFFFFFFF :
		((32'h00000001 << sync_len_i) - 32'h00000001);
	// leading bits of the sync pattern aligned to the low bits of the received word
	wire [31:0] pri_al = primary_sync_bytes_i >> (6'd32 - sync_len_i);
	wire [31:0] sec_al = secondary_sync_bytes_i >> (6'd32 - sync_len_i);
	wire [31:0] dp = (nsh ^ pri_al) & smask;
	wire [31:0] dsec = (nsh ^ sec_al) & smask;
	reg [5:0] qp;
	reg [5:0] qs;
	integer k;
	// quality is count of matching bits among the sync length
	always @* begin
		qp = sync_len_i;
		qs = sync_len_i;
		for (k = 0; k < 32; k = k + 1) begin
			qp = qp - {5'h00, dp[k]};
			qs = qs - {5'h00, dsec[k]};
		end
	end
	wire hit_p = (dp == 32'h00000000);
	wire hit_s = alt_sync_sel_i & (dsec == 32'h00000000);
	wire [7:0] rbyte = {rsh[6:0], rx_s};

	// two-flop synchroniser on the demodulator stream
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_m <= 1'b0;
			rx_s <= 1'b0;
			rv_m <= 1'b0;
			rv_s <= 1'b0;
		end else begin
			rx_m <= rx_bit_i;
			rx_s <= rx_m;
			rv_m <= rx_bit_valid_i;
			rv_s <= rv_m;
		end
	end

	// deframer: preamble, sync, fields, crc compare
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rs <= S_IDLE;
			rsh <= 32'h00000000;
			pre_run <= 5'h00;
			rcnt <= 16'h0000;
			rlen <= 16'h0000;
			rbit <= 3'h0;
			rcrc <= `RBPF_CRC_INIT;
			rcrc_got <= 32'h00000000;
			addr_bad <= 1'b0;
			rx_data_o <= 8'h00;
			rx_data_valid_o <= 1'b0;
			sync_quality_value_o <= 7'h00;
			sync_detect_o <= 1'b0;
			rx_frame_error_o <= 1'b0;
			rx_frame_ok_o <= 1'b0;
		end else begin
			rx_data_valid_o <= 1'b0;
			sync_detect_o <= 1'b0;
			rx_frame_error_o <= 1'b0;
			rx_frame_ok_o <= 1'b0;
			if (!rx_enable_i || !basic_fmt) begin
				rs <= S_IDLE;
				pre_run <= 5'h00;
			end else if (rv_s) begin
				rsh <= nsh;
				case (rs)
				S_IDLE: begin
					// alternating bits count as preamble
					pre_run <= (rx_s != rsh[0]) ? pre_run + 5'h01 : 5'h00;
					if (pre_run >= PRE_DETECT_BITS[4:0]) begin
						rs <= S_SYNC;
					end
				end
				S_SYNC: begin
					if (hit_p || hit_s) begin
						rs <= S_LEN;
						sync_detect_o <= 1'b1;
						sync_quality_value_o <= {hit_s & ~hit_p,
							(alt_sync_sel_i && qs > qp) ? qs : qp};
						rcnt <= 16'h0000;
						rbit <= 3'h0;
						rcrc <= `RBPF_CRC_INIT;
						rlen <= reg_len;
						addr_bad <= 1'b0;
					end
				end
				S_LEN, S_ADDR, S_PAY, S_CRC: begin
					rbit <= rbit + 3'h1;
					if (rs != S_CRC) begin
						rcrc <= crc_step(rcrc, rx_s);
					end
					if (rbit == 3'h7) begin
						rcnt <= rcnt + 16'h0001;
						if (rs == S_LEN) begin
							if (variable_length_enable_i) begin
								rlen <= length_field_width_i ? {rlen[7:0], rbyte} :
									{8'h00, rbyte};
							end
							if (!variable_length_enable_i ||
								!length_field_width_i || rcnt == 16'h0001) begin
								rs <= dest_address_enable_i ? S_ADDR : S_PAY;
								rcnt <= 16'h0000;
							end
						end else if (rs == S_ADDR) begin
							addr_bad <= (rbyte != rx_match_eff);
							rs <= S_PAY;
						end else if (rs == S_PAY) begin
							rx_data_o <= rbyte;
							rx_data_valid_o <= ~addr_bad;
						end else begin
							rcrc_got <= {rcrc_got[23:0], rbyte};
						end
						if (rs == S_PAY && rcnt + 16'h0001 >= rlen) begin
							rs <= S_CRC;
							rcnt <= 16'h0000;
						end
						if (rs == S_CRC && rcnt + 16'h0001 >= {13'h0000, crc_bytes_i}) begin
							rs <= S_POST;
						end
					end
				end
				S_POST: begin
					rs <= S_IDLE;
					pre_run <= 5'h00;
				end
				default: rs <= S_IDLE;
				endcase
			end
			// verdict once the crc bytes are in
			if (rs == S_POST) begin
				if (addr_bad || (crc_bytes_i != 3'h0 &&
					((rcrc_got ^ rcrc) & ((crc_bytes_i >= 3'h4) ? 32'hFFFFFFFF :
					((32'h00000001 << {crc_bytes_i, 3'h0}) - 32'h00000001))) !=
					32'h00000000)) begin
					rx_frame_error_o <= 1'b1;
				end else begin
					rx_frame_ok_o <= 1'b1;
				end
				// one verdict per frame, even when no further bits arrive
				rs <= S_IDLE;
				pre_run <= 5'h00;
			end
		end
	end
endmodule

// [test/rbpf_framer_monitor.sv]
// port-level assertions for the basic packet framer
`timescale 1ns/1ps
module rbpf_framer_monitor (
	input wire clk_i,
	input wire nrst_i,
	input wire [1:0] frame_format_select_i,
	input wire [5:0] sync_len_i,
	input wire alt_sync_sel_i,
	input wire tx_start_i,
	input wire tx_bit_en_i,
	input wire tx_bit_o,
	input wire tx_busy_o,
	input wire tx_done_o,
	input wire rx_data_valid_o,
	input wire [6:0] sync_quality_value_o,
	input wire sync_detect_o,
	input wire rx_frame_error_o,
	input wire rx_frame_ok_o
);
	// ----------------------------------------
	// properties, single clock domain
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	fmt_gate_a: assert property (
		tx_start_i && !tx_busy_o && frame_format_select_i != 2'h0 |=> !tx_busy_o)
		else $error("start taken outside basic format");
	start_taken_a: assert property (
		tx_start_i && !tx_busy_o && frame_format_select_i == 2'h0 |=> tx_busy_o)
		else $error("basic start not taken");
	bit_on_strobe_a: assert property (
		!$stable(tx_bit_o) |-> $past(tx_bit_en_i))
		else $error("tx bit moved without strobe");
	done_on_strobe_a: assert property (
		tx_done_o |-> $past(tx_bit_en_i) ##1 !tx_done_o)
		else $error("done not a single strobed pulse");
	byte_spacing_a: assert property (
		rx_data_valid_o |=> !rx_data_valid_o [*7])
		else $error("rx bytes closer than eight bits");
	one_verdict_a: assert property (
		!(rx_frame_ok_o && rx_frame_error_o))
		else $error("frame both good and bad");
	second_hit_a: assert property (
		sync_detect_o && !alt_sync_sel_i |-> ##[0:1] !sync_quality_value_o[6])
		else $error("secondary hit while search off");
	quality_len_a: assert property (
		sync_detect_o |-> ##[0:1] sync_quality_value_o[5:0] == sync_len_i)
		else $error("sync quality differs from length");
	sync_pulse_a: assert property (
		sync_detect_o |=> !sync_detect_o)
		else $error("sync flag longer than a cycle");
endmodule
bind rbpf_framer rbpf_framer_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
	.frame_format_select_i(frame_format_select_i), .sync_len_i(sync_len_i),
	.alt_sync_sel_i(alt_sync_sel_i), .tx_start_i(tx_start_i), .tx_bit_en_i(tx_bit_en_i),
	.tx_bit_o(tx_bit_o), .tx_busy_o(tx_busy_o), .tx_done_o(tx_done_o),
	.rx_data_valid_o(rx_data_valid_o), .sync_quality_value_o(sync_quality_value_o),
	.sync_detect_o(sync_detect_o), .rx_frame_error_o(rx_frame_error_o),
	.rx_frame_ok_o(rx_frame_ok_o));

// [test/rbpf_radio_model.sv]
// remote radio: bit strobes, captures tx bits, sends rx bits
`timescale 1ns/1ps
module rbpf_radio_model (
	input wire clk_i,
	input wire tx_busy_i,
	input wire tx_bit_i,
	output logic tx_bit_en_o,
	output logic rx_bit_o,
	output logic rx_bit_valid_o
);
	logic [1:0] div = 2'h0;
	logic taken = 1'b0;
	bit heard[$];
	initial begin
		tx_bit_en_o = 1'b0;
		rx_bit_o = 1'b0;
		rx_bit_valid_o = 1'b0;
	end
	// ----------------------------------------
	// strobe every fourth cycle, only while a frame is out
	// ----------------------------------------
	always @(posedge clk_i) begin
		div <= div + 2'h1;
		tx_bit_en_o <= tx_busy_i && div == 2'h3;
		taken <= tx_bit_en_o;
		if (taken) heard.push_back(tx_bit_i);
	end
	// one valid cycle per bit; the line shows the inverse between bits
	task send(input bit b[$]);
		foreach (b[k]) begin
			@(posedge clk_i);
			rx_bit_o <= b[k];
			rx_bit_valid_o <= 1'b1;
			@(posedge clk_i);
			rx_bit_o <= !b[k];
			rx_bit_valid_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask
endmodule

// [test/tb_top.sv]
// self-checking bench for the basic packet framer
`timescale 1ns/1ps
`include "rbpf_defines.vh"
`define CHK(got_v, want_v) begin \
	comparisons++; \
	if ((got_v) !== (want_v)) begin \
		mismatches++; \
		$display("FAIL at %0t got %0h want %0h", $time, got_v, want_v); \
	end \
end
module tb_top;
	logic clk_i = 1'b0, nrst_i = 1'b0, four_level_i = 1'b0, alt_sync_sel_i = 1'b0;
	logic variable_length_enable_i = 1'b1, length_field_width_i = 1'b0, rx_enable_i = 1'b0;
	logic dest_address_enable_i = 1'b1, tx_start_i = 1'b0, tx_data_valid_i = 1'b0;
	logic [1:0] frame_format_select_i = 2'h0, preamble_sel_i = 2'h0;
	logic [9:0] preamble_pairs_i = 10'h000;
	logic [5:0] sync_len_i = 6'h10;
	logic [31:0] primary_sync_bytes_i = 32'hA5C396F0, secondary_sync_bytes_i = 32'h5E1D2B87;
	logic [7:0] tx_length_high_i = 8'h00, tx_length_low_i = 8'h03, dest_address_i = 8'h5A;
	logic [7:0] rx_match_address_i = 8'h5A, postamble_pair_count_i = 8'h00, tx_data_i = 8'h00;
	logic [2:0] crc_bytes_i = 3'h0;
	wire tx_bit_en_i, rx_bit_i, rx_bit_valid_i, tx_data_ready_o, tx_bit_o, tx_busy_o;
	wire tx_done_o, rx_data_valid_o, sync_detect_o, rx_frame_error_o, rx_frame_ok_o;
	wire [7:0] rx_data_o;
	wire [6:0] sync_quality_value_o;
	int mismatches = 0, comparisons = 0, n_done, n_ok, n_err, n_sync;
	bit exp_bits[$];
	bit [7:0] pay[$], got[$];
	bit [31:0] crc;
	bit [15:0] lf = 16'h0003;
	bit [3:0] tab2[4] = '{4'h5, 4'hA, 4'h3, 4'hC};
	bit [3:0] tab4[4] = '{4'h7, 4'h2, 4'hD, 4'h8};
	rbpf_framer DUT (.clk_i(clk_i), .nrst_i(nrst_i), .frame_format_select_i(frame_format_select_i),
		.preamble_pairs_i(preamble_pairs_i), .preamble_sel_i(preamble_sel_i),
		.four_level_i(four_level_i), .sync_len_i(sync_len_i),
		.primary_sync_bytes_i(primary_sync_bytes_i),
		.secondary_sync_bytes_i(secondary_sync_bytes_i), .alt_sync_sel_i(alt_sync_sel_i),
		.tx_length_high_i(tx_length_high_i), .tx_length_low_i(tx_length_low_i),
		.variable_length_enable_i(variable_length_enable_i),
		.length_field_width_i(length_field_width_i),
		.dest_address_enable_i(dest_address_enable_i), .dest_address_i(dest_address_i),
		.rx_match_address_i(rx_match_address_i), .crc_bytes_i(crc_bytes_i),
		.postamble_pair_count_i(postamble_pair_count_i), .tx_start_i(tx_start_i),
		.tx_bit_en_i(tx_bit_en_i), .tx_data_valid_i(tx_data_valid_i),
		.tx_data_ready_o(tx_data_ready_o), .tx_data_i(tx_data_i), .tx_bit_o(tx_bit_o),
		.tx_busy_o(tx_busy_o), .tx_done_o(tx_done_o), .rx_enable_i(rx_enable_i),
		.rx_bit_i(rx_bit_i), .rx_bit_valid_i(rx_bit_valid_i), .rx_data_o(rx_data_o),
		.rx_data_valid_o(rx_data_valid_o), .sync_quality_value_o(sync_quality_value_o),
		.sync_detect_o(sync_detect_o), .rx_frame_error_o(rx_frame_error_o),
		.rx_frame_ok_o(rx_frame_ok_o));
	rbpf_radio_model RM (.clk_i(clk_i), .tx_busy_i(tx_busy_o), .tx_bit_i(tx_bit_o),
		.tx_bit_en_o(tx_bit_en_i), .rx_bit_o(rx_bit_i), .rx_bit_valid_o(rx_bit_valid_i));
	// ----------------------------------------
	// clock, event counters and frame builder
	// ----------------------------------------
	always #25 clk_i = ~clk_i;
	// pulses are counted so that tests need not hit the exact cycle
	always @(posedge clk_i) begin
		if (tx_done_o === 1'b1) n_done++;
		if (rx_frame_ok_o === 1'b1) n_ok++;
		if (rx_frame_error_o === 1'b1) n_err++;
		if (sync_detect_o === 1'b1) n_sync++;
		if (rx_data_valid_o === 1'b1) got.push_back(rx_data_o);
	end
	// msb-first bits, optionally folded into the running crc
	task put(input int n, input bit [31:0] v, input bit into_crc);
		bit b;
		for (int k = n - 1; k >= 0; k--) begin
			b = v[k];
			exp_bits.push_back(b);
			if (into_crc) crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ b) ? `RBPF_CRC_POLY : 32'h0);
		end
	endtask
	// expected air bits for the present settings
	task build(input bit [31:0] word);
		bit [3:0] pat;
		exp_bits = {};
		crc = `RBPF_CRC_INIT;
		pat = four_level_i ? tab4[preamble_sel_i] : tab2[preamble_sel_i];
		for (int k = 0; k < 2 * preamble_pairs_i; k++) exp_bits.push_back(pat[3 - k % 4]);
		put(sync_len_i, word >> (32 - sync_len_i), 1'b0);
		if (variable_length_enable_i && length_field_width_i) put(16, lf, 1'b1);
		else put(8, lf[7:0], 1'b1);
		if (dest_address_enable_i) put(8, dest_address_i, 1'b1);
		foreach (pay[k]) put(8, pay[k], 1'b1);
		put(8 * crc_bytes_i, crc, 1'b0);
		for (int k = 0; k < postamble_pair_count_i; k++) put(2, 2'h1, 1'b0);
	endtask
	// fill the fifo, start a frame and compare what went on air
	task run_tx();
		int errs;
		logic rdy;
		@(posedge clk_i);
		build(alt_sync_sel_i ? secondary_sync_bytes_i : primary_sync_bytes_i);
		foreach (pay[k]) begin
			tx_data_i <= pay[k];
			tx_data_valid_i <= 1'b1;
			// ready is judged as it stands before the taking edge
			do begin
				@(negedge clk_i);
				rdy = tx_data_ready_o;
				@(posedge clk_i);
			end while (rdy !== 1'b1);
		end
		tx_data_valid_i <= 1'b0;
		@(posedge clk_i);
		if (pay.size() == 16) `CHK(tx_data_ready_o, 1'b0)
		n_done = 0;
		RM.heard = {};
		tx_start_i <= 1'b1;
		@(posedge clk_i);
		tx_start_i <= 1'b0;
		for (int w = 0; w < 4000 && n_done == 0; w++) @(posedge clk_i);
		errs = 0;
		foreach (exp_bits[k]) if (k >= RM.heard.size() || RM.heard[k] != exp_bits[k]) errs++;
		`CHK(errs, 0)
		`CHK(n_done, 1)
		repeat (8) @(posedge clk_i);
	endtask
	task final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog well beyond the expected run of some six thousand cycles
	initial begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		final_report();
	end
	// main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (int f = 1; f < 4; f++) begin
			frame_format_select_i <= f[1:0];
			tx_start_i <= 1'b1;
			@(posedge clk_i);
			tx_start_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			`CHK(tx_busy_o, 1'b0)
		end
		frame_format_select_i <= 2'h0;
		$display("format select test done");
		// preamble patterns of both tables but the first (sent with zero pairs), sync words and field widths
		for (int i = 0; i < 8; i++) begin
			four_level_i <= i[2];
			preamble_sel_i <= i[1:0];
			preamble_pairs_i <= 10'(3 * i);
			sync_len_i <= 6'(32 - 4 * i);
			alt_sync_sel_i <= i[0];
			length_field_width_i <= i[1];
			dest_address_enable_i <= !i[0];
			dest_address_i <= 8'hC0 + 8'(i);
			crc_bytes_i <= 3'(i % 5);
			postamble_pair_count_i <= 8'(2 * i);
			pay = {8'h11, 8'h22};
			if (i[0]) pay.push_back(8'h33);
			run_tx();
		end
		$display("tx frame tests done");
		dest_address_enable_i <= 1'b0;
		tx_length_low_i <= 8'h10;
		lf = 16'h0010;
		pay = {};
		for (int k = 0; k < 16; k++) pay.push_back(8'(k * 17));
		run_tx();
		$display("fifo fill test done");
		four_level_i <= 1'b0;
		preamble_sel_i <= 2'h0;
		preamble_pairs_i <= 10'h00A;
		sync_len_i <= 6'h10;
		length_field_width_i <= 1'b0;
		dest_address_enable_i <= 1'b1;
		tx_length_low_i <= 8'h03;
		crc_bytes_i <= 3'h2;
		postamble_pair_count_i <= 8'h00;
		rx_enable_i <= 1'b1;
		pay = {8'hA7, 8'h3C};
		// primary, secondary, wrong address, fixed length, corrupted payload
		for (int j = 0; j < 5; j++) begin
			alt_sync_sel_i <= (j == 1);
			dest_address_i <= (j == 2) ? 8'h5B : 8'h5A;
			variable_length_enable_i <= (j != 3);
			lf = (j == 3) ? 16'h0009 : 16'h0003;
			@(posedge clk_i);
			n_ok = 0;
			n_err = 0;
			n_sync = 0;
			got = {};
			build(j == 1 ? secondary_sync_bytes_i : primary_sync_bytes_i);
			if (j == 4) exp_bits[60] = !exp_bits[60];
			RM.send(exp_bits);
			repeat (40) @(posedge clk_i);
			`CHK(n_sync, 1)
			`CHK(sync_quality_value_o, {j == 1, 6'h10})
			`CHK(n_ok, int'(j < 2 || j == 3))
			`CHK(n_err, int'(j == 2 || j == 4))
			`CHK(got.size(), (j == 2) ? 0 : 2)
			if (j != 2) `CHK(got[0], pay[0])
		end
		$display("rx frame tests done");
		final_report();
	end
endmodule
